// ==== logic/flash_arr_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface flash_arr_if;
    logic [14:0] addr;
    logic [15:0] wdata;
    logic [1:0] laneEn;
    logic progWr;
    logic eraseWr;
    logic ovlWr;
    logic ovlRd;
    logic [15:0] rdata;
    modport ctrl(output addr, wdata, laneEn, progWr, eraseWr, ovlWr, ovlRd, input rdata);
    modport store(input addr, wdata, laneEn, progWr, eraseWr, ovlWr, ovlRd, output rdata);
endinterface
`default_nettype wire

// ==== logic/flash_map_pkg.sv ====
`default_nettype none
package flash_map_pkg;
    // address map of the flash region and the control registers
    localparam logic [15:0] FLASH_TOP = 16'h7fff;
    localparam logic [15:0] MODE_CTL_ADDR = 16'hff80;
    localparam logic [15:0] LARGE_SEL_ADDR = 16'hff82;
    localparam logic [15:0] SMALL_SEL_ADDR = 16'hff83;
    localparam logic [15:0] WAIT_CTL_ADDR = 16'hffc2;
    localparam logic [15:0] REG_WIN_BASE = 16'hff80;
    // reset values and fixed read values
    localparam logic [7:0] MODE_CTL_RST = 8'h00;
    localparam logic [7:0] LARGE_SEL_RST = 8'hf0;
    localparam logic [7:0] SMALL_SEL_RST = 8'h00;
    localparam logic [7:0] WAIT_CTL_RST = 8'h08;
    localparam logic [7:0] DENIED_RD = 8'hff;
    localparam logic [7:0] MODE_CTL_WMASK = 8'h0f;
    localparam logic [7:0] LARGE_SEL_WMASK = 8'h0f;
    // field positions
    localparam int VPP_BIT = 7;
    localparam int EV_BIT = 3;
    localparam int PV_BIT = 2;
    localparam int E_BIT = 1;
    localparam int P_BIT = 0;
    localparam int RAMS_BIT = 7;
    localparam int RAM0_BIT = 6;
    // ram overlay windows, one kbyte each
    localparam logic [15:0] OVL_BASE0 = 16'h0000;
    localparam logic [15:0] OVL_BASE1 = 16'h0400;
    // timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned MAX_BPS = 9600;
    localparam int unsigned MIN_BIT_CYC = CLK_HZ / MAX_BPS;
    localparam int unsigned BOOT_BITS = 9;
    localparam int unsigned FRAME_BITS = 10;
    localparam logic [1:0] SYNC_SETTLE = 2'h2;
    // exclusive end address of each block: small 0..7, then large 0..3
    localparam logic [15:0] BLK_END [12] = '{16'h0080, 16'h0100, 16'h0180,
        16'h0200, 16'h0400, 16'h0800, 16'h0c00, 16'h1000, 16'h2000,
        16'h4000, 16'h6000, 16'h8000};

    typedef enum logic [1:0] {
        MAP_ILLEGAL = 2'b00,
        MAP_EXTERNAL = 2'b01,
        MAP_FLASH_A = 2'b10,
        MAP_FLASH_B = 2'b11
    } strap_t;

    typedef enum logic [5:0] {
        OP_READ = 6'b000001,
        OP_PROG = 6'b000010,
        OP_PVFY = 6'b000100,
        OP_ERASE = 6'b001000,
        OP_EVFY = 6'b010000,
        OP_PREVFY = 6'b100000
    } flash_op_t;

    // one-hot block that holds a flash address, bit 11..8 large, 7..0 small
    function automatic logic [11:0] blockHit(input logic [15:0] a);
        logic [11:0] hit;
        logic done;
        hit = 12'h000;
        done = 1'b0;
        for (int i = 0; i < 12; i++) begin
            if (!done && a < BLK_END[i]) begin
                hit[i] = 1'b1;
                done = 1'b1;
            end
        end
        return hit;
    endfunction
endpackage
`default_nettype wire

// ==== logic/flash_store.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_store #(
    parameter int WORDS = 16384,
    parameter int OVL_WORDS = 512
) (
    input wire logic ref_clk,
    flash_arr_if.store arr
);
    logic [15:0] cells [WORDS];
    logic [15:0] ovlRam [OVL_WORDS];

    // programming only clears bits, erasing sets the enabled byte lanes to ones
    always_ff @(posedge ref_clk) begin
        for (int b = 0; b < 2; b++) begin
            if (arr.laneEn[b]) begin
                if (arr.progWr) begin
                    cells[arr.addr[14:1]][b*8 +: 8] <=
                        cells[arr.addr[14:1]][b*8 +: 8] & arr.wdata[b*8 +: 8];
                end else if (arr.eraseWr) begin
                    cells[arr.addr[14:1]][b*8 +: 8] <= 8'hff;
                end
                if (arr.ovlWr) begin
                    ovlRam[arr.addr[9:1]][b*8 +: 8] <= arr.wdata[b*8 +: 8];
                end
            end
        end
    end

    // combinational read so the controller answers in the second state
    assign arr.rdata = arr.ovlRd ? ovlRam[arr.addr[9:1]] : cells[arr.addr[14:1]];
endmodule
`default_nettype wire

// ==== logic/onchip_flash_map_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// - flash sits at addresses zero to 32 kbytes
// - mode straps pick flash or external memory
// - flash data path is sixteen bits wide
// - every flash read answers in two states
// - control registers reachable only with 12 V
// - mode two without 12 V forwards registers
// - mode three without 12 V: ignore, read ones
// - external mode: registers unwritable, read ones
// - flash modes reset registers to zero, f0, zero
// - six flash operating modes are decoded
// - four large, eight small selectable blocks
// - boot mode matches host bit rate, 9600 max
// - boot data uses serial channel one pins
// - ram window can overlay part of flash
// - mode control bit 7 shows 12 V present
// - only selected blocks may be programmed, erased
module onchip_flash_map_ctrl
    import flash_map_pkg::*;
#(
    parameter int unsigned MIN_LOW_CYC = BOOT_BITS * MIN_BIT_CYC,
    parameter int MEAS_W = 20
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [15:0] cpuAddr,
    input wire logic cpuRd,
    input wire logic cpuWr,
    input wire logic cpuByte,
    input wire logic [15:0] cpuWdata,
    output logic [15:0] cpuRdata,
    output logic cpuAck,
    output logic extRd,
    output logic extWr,
    output logic [15:0] extAddr,
    output logic [15:0] extWdata,
    input wire logic prog_supply_pin,
    input wire logic mode_strap_hi,
    input wire logic mode_strap_lo,
    input wire logic bootEnable,
    input wire logic boot_serial_in,
    output logic boot_serial_out,
    output flash_op_t flashOp,
    output logic [11:0] blockEnable
);
    typedef enum logic [3:0] {
        BT_IDLE = 4'b0001,
        BT_MEASURE = 4'b0010,
        BT_SEND = 4'b0100,
        BT_DONE = 4'b1000
    } boot_t;

    logic [4:0] pinSyncd;
    logic vppS, bootS, rxS;
    strap_t strap_ff, nxt_strap;
    logic modeValid_ff, nxt_modeValid;
    logic [1:0] settle_ff, nxt_settle;
    logic [7:0] modeCtl_ff, nxt_modeCtl, largeSel_ff, nxt_largeSel;
    logic [7:0] smallSel_ff, nxt_smallSel, waitCtl_ff, nxt_waitCtl;
    logic [15:0] rdata_ff, nxt_rdata, extAddr_ff, nxt_extAddr, extWdata_ff, nxt_extWdata;
    logic ack_ff, nxt_ack, extRd_ff, nxt_extRd, extWr_ff, nxt_extWr;
    flash_op_t op_ff, nxt_op;
    logic [11:0] blkEn_ff, nxt_blkEn;
    logic [1:0] laneEn;
    logic inFlash, regWin, wsHit, flashOn, regOk, fwdReg, ovlHit, blkOk;
    logic [7:0] wrHi, wrLo;
    flash_arr_if arr ();

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    pin_sync #(.W(5)) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pinIn({prog_supply_pin, mode_strap_hi, mode_strap_lo, bootEnable, boot_serial_in}),
        .pinOut(pinSyncd)
    );
    assign vppS = pinSyncd[4];
    assign bootS = pinSyncd[1];
    assign rxS = pinSyncd[0];

    flash_store u_store (
        .ref_clk(ref_clk),
        .arr(arr)
    );

    // byte of a register for a read; a denied window reads all ones
    function automatic logic [7:0] pickByte(input logic [15:0] a, input logic [7:0] ctl,
        input logic [7:0] lg, input logic [7:0] sm, input logic [7:0] ws,
        input logic ok, input logic vpp);
        logic [7:0] v;
        v = 8'h00;
        if (a == WAIT_CTL_ADDR) begin
            v = ws;
        end else if (a[15:2] == REG_WIN_BASE[15:2] && !ok) begin
            v = DENIED_RD;
        end else if (a == MODE_CTL_ADDR) begin
            v = {vpp, 3'h0, ctl[3:0]};
        end else if (a == LARGE_SEL_ADDR) begin
            v = lg | ~LARGE_SEL_WMASK;
        end else if (a == SMALL_SEL_ADDR) begin
            v = sm;
        end
        return v;
    endfunction

    // true when the write covers the byte lane of register address t
    function automatic logic laneHit(input logic [15:0] a, input logic [15:0] t,
        input logic [1:0] lanes);
        return a[15:1] == t[15:1] && (t[0] ? lanes[0] : lanes[1]);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // strap capture once the synchroniser has settled after reset
    always_comb begin
        nxt_settle = settle_ff;
        nxt_strap = strap_ff;
        nxt_modeValid = modeValid_ff;
        if (!modeValid_ff) begin
            nxt_settle = settle_ff + 2'h1;
            if (settle_ff == SYNC_SETTLE) begin
                nxt_strap = strap_t'(pinSyncd[3:2]);
                nxt_modeValid = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            settle_ff <= 2'h0;
            strap_ff <= MAP_ILLEGAL;
            modeValid_ff <= 1'b0;
        end else begin
            settle_ff <= nxt_settle;
            strap_ff <= nxt_strap;
            modeValid_ff <= nxt_modeValid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // access classification
    always_comb begin
        laneEn = cpuByte ? (cpuAddr[0] ? 2'b01 : 2'b10) : 2'b11;
        inFlash = cpuAddr <= FLASH_TOP;
        regWin = cpuAddr[15:2] == REG_WIN_BASE[15:2];
        wsHit = cpuAddr[15:1] == WAIT_CTL_ADDR[15:1];
        flashOn = modeValid_ff && (strap_ff == MAP_FLASH_A || strap_ff == MAP_FLASH_B);
        regOk = flashOn && vppS;
        fwdReg = regWin && !vppS && modeValid_ff && strap_ff == MAP_FLASH_A;
        ovlHit = inFlash && waitCtl_ff[RAMS_BIT] && cpuAddr[15:10] ==
            (waitCtl_ff[RAM0_BIT] ? OVL_BASE1[15:10] : OVL_BASE0[15:10]);
        blkOk = (blockHit(cpuAddr) & blkEn_ff) != 12'h000;
        wrHi = cpuWdata[15:8];
        wrLo = cpuWdata[7:0];
    end

    assign arr.addr = cpuAddr[14:0];
    assign arr.wdata = cpuWdata;
    assign arr.laneEn = laneEn;
    assign arr.ovlRd = ovlHit;
    assign arr.ovlWr = cpuWr && ovlHit && flashOn;
    assign arr.progWr = cpuWr && inFlash && flashOn && !ovlHit && op_ff == OP_PROG && blkOk;
    assign arr.eraseWr = cpuWr && inFlash && flashOn && !ovlHit && op_ff == OP_ERASE && blkOk;

    ////////////////////////////////////////////////////////////////////////
    // register file; without supply the flash registers sit at reset value
    always_comb begin
        nxt_modeCtl = modeCtl_ff;
        nxt_largeSel = largeSel_ff;
        nxt_smallSel = smallSel_ff;
        nxt_waitCtl = waitCtl_ff;
        if (cpuWr && wsHit && laneHit(cpuAddr, WAIT_CTL_ADDR, laneEn)) begin
            nxt_waitCtl = wrHi;
        end
        if (!regOk) begin
            nxt_modeCtl = MODE_CTL_RST;
            nxt_largeSel = LARGE_SEL_RST;
            nxt_smallSel = SMALL_SEL_RST;
        end else if (cpuWr && regWin) begin
            if (laneHit(cpuAddr, MODE_CTL_ADDR, laneEn)) begin
                nxt_modeCtl = wrHi & MODE_CTL_WMASK;
            end
            if (laneHit(cpuAddr, LARGE_SEL_ADDR, laneEn)) begin
                nxt_largeSel = (wrHi & LARGE_SEL_WMASK) | LARGE_SEL_RST;
            end
            if (laneHit(cpuAddr, SMALL_SEL_ADDR, laneEn)) begin
                nxt_smallSel = wrLo;
            end
        end
    end

    // operating mode decode; two bits at once falls back to read
    always_comb begin
        case (modeCtl_ff[3:0])
            4'h1: nxt_op = OP_PROG;
            4'h2: nxt_op = OP_ERASE;
            4'h4: nxt_op = (largeSel_ff[3:0] == 4'h0 && smallSel_ff == 8'h00) ?
                OP_PREVFY : OP_PVFY;
            4'h8: nxt_op = OP_EVFY;
            default: nxt_op = OP_READ;
        endcase
        nxt_blkEn = regOk ? {largeSel_ff[3:0], smallSel_ff} : 12'h000;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            modeCtl_ff <= MODE_CTL_RST;
            largeSel_ff <= LARGE_SEL_RST;
            smallSel_ff <= SMALL_SEL_RST;
            waitCtl_ff <= WAIT_CTL_RST;
            op_ff <= OP_READ;
            blkEn_ff <= 12'h000;
        end else begin
            modeCtl_ff <= nxt_modeCtl;
            largeSel_ff <= nxt_largeSel;
            smallSel_ff <= nxt_smallSel;
            waitCtl_ff <= nxt_waitCtl;
            op_ff <= nxt_op;
            blkEn_ff <= nxt_blkEn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus answer: one registered state after the request state
    always_comb begin
        nxt_ack = 1'b0;
        nxt_rdata = rdata_ff;
        nxt_extRd = 1'b0;
        nxt_extWr = 1'b0;
        nxt_extAddr = extAddr_ff;
        nxt_extWdata = extWdata_ff;
        if (cpuRd || cpuWr) begin
            if (inFlash && flashOn) begin
                nxt_ack = 1'b1;
                if (cpuRd) begin
                    nxt_rdata = arr.rdata;
                end
            end else if (inFlash || fwdReg) begin
                nxt_extRd = cpuRd && !cpuWr;
                nxt_extWr = cpuWr;
                nxt_extAddr = cpuAddr;
                nxt_extWdata = cpuWdata;
            end else if (regWin || wsHit) begin
                nxt_ack = 1'b1;
                if (cpuRd) begin
                    nxt_rdata = {pickByte({cpuAddr[15:1], 1'b0}, modeCtl_ff, largeSel_ff,
                        smallSel_ff, waitCtl_ff, regOk, vppS),
                        pickByte({cpuAddr[15:1], 1'b1}, modeCtl_ff, largeSel_ff,
                        smallSel_ff, waitCtl_ff, regOk, vppS)};
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ack_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            extRd_ff <= 1'b0;
            extWr_ff <= 1'b0;
            extAddr_ff <= 16'h0000;
            extWdata_ff <= 16'h0000;
        end else begin
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
            extRd_ff <= nxt_extRd;
            extWr_ff <= nxt_extWr;
            extAddr_ff <= nxt_extAddr;
            extWdata_ff <= nxt_extWdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // boot autobaud: host sends a zero byte, its low span is nine bit times
    boot_t boot_ff, nxt_boot;
    logic [MEAS_W-1:0] meas_ff, nxt_meas, bitCyc_ff, nxt_bitCyc, bitTmr_ff, nxt_bitTmr;
    logic [3:0] bitCnt_ff, nxt_bitCnt;
    logic tx_ff, nxt_tx;

    always_comb begin
        nxt_boot = boot_ff;
        nxt_meas = meas_ff;
        nxt_bitCyc = bitCyc_ff;
        nxt_bitTmr = bitTmr_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_tx = 1'b1;
        case (boot_ff)
            BT_IDLE: begin
                nxt_meas = MEAS_W'(1);
                if (bootS && !rxS) begin
                    nxt_boot = BT_MEASURE;
                end
            end
            BT_MEASURE: begin
                if (meas_ff != '1) begin
                    nxt_meas = meas_ff + MEAS_W'(1);
                end
                if (rxS) begin
                    if (meas_ff >= MEAS_W'(MIN_LOW_CYC)) begin
                        nxt_bitCyc = MEAS_W'(meas_ff / MEAS_W'(BOOT_BITS));
                        nxt_bitTmr = MEAS_W'(0);
                        nxt_bitCnt = 4'h0;
                        nxt_boot = BT_SEND;
                    end else begin
                        nxt_boot = BT_IDLE;
                    end
                end
            end
            BT_SEND: begin
                // start bit then eight zero data bits, stop bit idles high
                nxt_tx = bitCnt_ff == 4'(FRAME_BITS - 1);
                nxt_bitTmr = bitTmr_ff + MEAS_W'(1);
                if (bitTmr_ff == bitCyc_ff - MEAS_W'(1)) begin
                    nxt_bitTmr = MEAS_W'(0);
                    nxt_bitCnt = bitCnt_ff + 4'h1;
                    if (bitCnt_ff == 4'(FRAME_BITS - 1)) begin
                        nxt_boot = BT_DONE;
                    end
                end
            end
            BT_DONE: begin
                if (!bootS) begin
                    nxt_boot = BT_IDLE;
                end
            end
            default: nxt_boot = BT_IDLE;
        endcase
        if (!bootS) begin
            nxt_boot = BT_IDLE;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            boot_ff <= BT_IDLE;
            meas_ff <= '0;
            bitCyc_ff <= '0;
            bitTmr_ff <= '0;
            bitCnt_ff <= 4'h0;
            tx_ff <= 1'b1;
        end else begin
            boot_ff <= nxt_boot;
            meas_ff <= nxt_meas;
            bitCyc_ff <= nxt_bitCyc;
            bitTmr_ff <= nxt_bitTmr;
            bitCnt_ff <= nxt_bitCnt;
            tx_ff <= nxt_tx;
        end
    end

    assign cpuRdata = rdata_ff;
    assign cpuAck = ack_ff;
    assign extRd = extRd_ff;
    assign extWr = extWr_ff;
    assign extAddr = extAddr_ff;
    assign extWdata = extWdata_ff;
    assign boot_serial_out = tx_ff;
    assign flashOp = op_ff;
    assign blockEnable = blkEn_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks on the design's own outputs and internal registers
    twoState_a: assert property (@(posedge ref_clk) disable iff (reset)
        (cpuRd && !cpuWr && inFlash && flashOn) |=> cpuAck && cpuRdata == $past(arr.rdata))
        else $error("flash read not answered in two states");
    extMode_a: assert property (@(posedge ref_clk) disable iff (reset)
        (cpuRd && !cpuWr && inFlash && modeValid_ff && strap_ff == MAP_EXTERNAL)
        |=> extRd && !cpuAck && extAddr == $past(cpuAddr))
        else $error("external mode flash read not forwarded");
    noSupply_a: assert property (@(posedge ref_clk) disable iff (reset)
        (!vppS && cpuWr && regWin) |=> modeCtl_ff == MODE_CTL_RST [*2])
        else $error("control register written without supply");
    fwdRegs_a: assert property (@(posedge ref_clk) disable iff (reset)
        (cpuWr && fwdReg) |=> extWr && !cpuAck)
        else $error("mode two register write not forwarded");
    denyRead_a: assert property (@(posedge ref_clk) disable iff (reset)
        (cpuRd && !cpuWr && regWin && !regOk && !fwdReg) |=> cpuAck && cpuRdata == 16'hffff)
        else $error("denied register read not all ones");
    extRegs_a: assert property (@(posedge ref_clk) disable iff (reset)
        (modeValid_ff && strap_ff == MAP_EXTERNAL) |-> ##1 blockEnable == 12'h000)
        else $error("external mode left blocks enabled");
    initVal_a: assert property (@(posedge ref_clk) disable iff (reset)
        !regOk |=> largeSel_ff == LARGE_SEL_RST && smallSel_ff == SMALL_SEL_RST)
        else $error("select registers not at initial value");
    supplyFlag_a: assert property (@(posedge ref_clk) disable iff (reset)
        (cpuRd && !cpuWr && cpuAddr[15:1] == MODE_CTL_ADDR[15:1] && regOk)
        |=> cpuRdata[15] == $past(vppS) && cpuRdata[14:12] == 3'h0)
        else $error("supply flag reads wrong");
    blockGate_a: assert property (@(posedge ref_clk) disable iff (reset)
        (arr.progWr || arr.eraseWr) |-> (blockHit(cpuAddr) & {largeSel_ff[3:0], smallSel_ff})
        != 12'h000 && $past(regOk))
        else $error("unselected block altered");
    opDecode_a: assert property (@(posedge ref_clk) disable iff (reset)
        (modeCtl_ff[3:0] == 4'h3) |=> flashOp == OP_READ)
        else $error("conflicting mode bits not rejected");
    baudFloor_a: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(boot_ff == BT_SEND) |-> bitCyc_ff >= MEAS_W'(MIN_LOW_CYC / BOOT_BITS))
        else $error("bit rate above limit accepted");
endmodule
`default_nettype wire

// ==== logic/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 5
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinOut
);
    logic [W-1:0] stage1_ff;
    logic [W-1:0] stage2_ff;

    // two flops; only the second stage is read outside
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= pinIn;
            stage2_ff <= stage1_ff;
        end
    end
    assign pinOut = stage2_ff;
endmodule
`default_nettype wire

// ==== tb/cpu_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
    input wire logic ref_clk,
    input wire logic cpuAck,
    input wire logic extRd,
    input wire logic extWr,
    output logic [15:0] cpuAddr,
    output logic cpuRd,
    output logic cpuWr,
    output logic cpuByte,
    output logic [15:0] cpuWdata
);
    // idle bus at time zero
    initial begin
        cpuAddr = 16'h0000;
        cpuRd = 1'b0;
        cpuWr = 1'b0;
        cpuByte = 1'b0;
        cpuWdata = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////
    // one request state, answer taken in the state after it
    task automatic xfer(input logic wr, input logic bt, input logic [15:0] a,
            input logic [15:0] d, output logic [2:0] ans);
        @(negedge ref_clk);
        cpuAddr = a;
        cpuWdata = d;
        cpuByte = bt;
        cpuWr = wr;
        cpuRd = !wr;
        @(negedge ref_clk);
        ans = {cpuAck, extRd, extWr};
        // released lines show the inverse so stale values never match
        cpuRd = 1'b0;
        cpuWr = 1'b0;
        cpuAddr = ~a;
        cpuWdata = ~d;
    endtask
endmodule
`default_nettype wire

// ==== tb/onchip_flash_map_ctrl_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module onchip_flash_map_ctrl_bench;
    import flash_map_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic supply = 1'b1;
    logic strapHi = 1'b1;
    logic strapLo = 1'b1;
    logic bootEn = 1'b0;
    logic rxPin = 1'b1;
    logic txPin;
    logic [15:0] cpuAddr, cpuWdata, cpuRdata, extAddr, extWdata;
    logic cpuRd, cpuWr, cpuByte, cpuAck, extRd, extWr;
    flash_op_t flashOp;
    logic [11:0] blockEnable;
    logic [2:0] ans;
    int n_errors = 0;
    int compares = 0;
    // 10 MHz clock
    always #50 ref_clk = ~ref_clk;
    // boot link pins idle until the boot scenario drives them
    onchip_flash_map_ctrl #(.MIN_LOW_CYC(90)) i_onchip_flash_map_ctrl (
        .ref_clk(ref_clk), .reset(reset), .cpuAddr(cpuAddr), .cpuRd(cpuRd),
        .cpuWr(cpuWr), .cpuByte(cpuByte), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
        .cpuAck(cpuAck), .extRd(extRd), .extWr(extWr), .extAddr(extAddr),
        .extWdata(extWdata), .prog_supply_pin(supply), .mode_strap_hi(strapHi),
        .mode_strap_lo(strapLo), .bootEnable(bootEn), .boot_serial_in(rxPin),
        .boot_serial_out(txPin), .flashOp(flashOp), .blockEnable(blockEnable));
    cpu_core_model i_cpu_core_model (.ref_clk(ref_clk), .cpuAck(cpuAck), .extRd(extRd),
        .extWr(extWr), .cpuAddr(cpuAddr), .cpuRd(cpuRd), .cpuWr(cpuWr),
        .cpuByte(cpuByte), .cpuWdata(cpuWdata));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // straps are only captured after reset, so a mode change needs one
    task automatic restart(input logic hi, input logic lo, input logic vpp);
        @(negedge ref_clk);
        reset = 1'b1;
        strapHi = hi;
        strapLo = lo;
        supply = vpp;
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic acc(input logic wr, input logic bt, input logic [15:0] a,
            input logic [15:0] d, input logic [2:0] expAns);
        i_cpu_core_model.xfer(wr, bt, a, d, ans);
        chk("answer", {13'h0000, expAns}, {13'h0000, ans});
    endtask
    // decode of the mode register lags the write by one state
    task automatic setOp(input logic [7:0] v, input flash_op_t op);
        acc(1'b1, 1'b1, MODE_CTL_ADDR, {v, 8'h00}, 3'b100);
        @(negedge ref_clk);
        chk("flashOp", {10'h000, op}, {10'h000, flashOp});
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic regResetValues;
        restart(1'b1, 1'b1, 1'b1);
        acc(1'b0, 1'b0, MODE_CTL_ADDR, 16'h0000, 3'b100);
        chk("mode ctl", {MODE_CTL_RST | 8'h80, 8'h00}, cpuRdata);
        acc(1'b0, 1'b0, LARGE_SEL_ADDR, 16'h0000, 3'b100);
        chk("block sel", {LARGE_SEL_RST, SMALL_SEL_RST}, cpuRdata);
        acc(1'b0, 1'b1, WAIT_CTL_ADDR, 16'h0000, 3'b100);
        chk("wait ctl", {8'h00, WAIT_CTL_RST}, {8'h00, cpuRdata[15:8]});
        acc(1'b0, 1'b0, 16'h8000, 16'h0000, 3'b000);
    endtask
    task automatic programFlow;
        acc(1'b1, 1'b1, LARGE_SEL_ADDR, 16'h0100, 3'b100);
        setOp(8'h02, OP_ERASE);
        chk("blocks", 16'h0100, {4'h0, blockEnable});
        acc(1'b1, 1'b0, 16'h1000, 16'h0000, 3'b100);
        acc(1'b0, 1'b0, 16'h1000, 16'h0000, 3'b100);
        chk("erased", 16'hffff, cpuRdata);
        setOp(8'h01, OP_PROG);
        acc(1'b1, 1'b0, 16'h1000, 16'h5aa5, 3'b100);
        acc(1'b0, 1'b0, 16'h1000, 16'h0000, 3'b100);
        chk("programmed", 16'h5aa5, cpuRdata);
        setOp(8'h04, OP_PVFY);
        setOp(8'h08, OP_EVFY);
        acc(1'b1, 1'b1, LARGE_SEL_ADDR, 16'h0000, 3'b100);
        setOp(8'h04, OP_PREVFY);
        // flash cells at 0x0400 are unwritten, so a missed overlay reads unknown
        acc(1'b1, 1'b1, WAIT_CTL_ADDR, 16'hc000, 3'b100);
        acc(1'b1, 1'b0, 16'h0400, 16'h1234, 3'b100);
        acc(1'b0, 1'b0, 16'h0400, 16'h0000, 3'b100);
        chk("overlay", 16'h1234, cpuRdata);
        acc(1'b1, 1'b1, WAIT_CTL_ADDR, {WAIT_CTL_RST, 8'h00}, 3'b100);
    endtask
    // host zero byte at ten states a bit; the answer's low span is nine bits
    task automatic bootBaud;
        int lowCyc;
        lowCyc = 0;
        bootEn = 1'b1;
        repeat (4) @(negedge ref_clk);
        rxPin = 1'b0;
        repeat (90) @(negedge ref_clk);
        rxPin = 1'b1;
        for (int i = 0; i < 200 && (lowCyc == 0 || !txPin); i++) begin
            @(negedge ref_clk);
            if (!txPin) lowCyc++;
        end
        chk("tx low states", 16'h005a, 16'(lowCyc));
        bootEn = 1'b0;
    endtask
    task automatic supplyOff;
        supply = 1'b0;
        repeat (3) @(negedge ref_clk);
        acc(1'b1, 1'b1, SMALL_SEL_ADDR, 16'h00ff, 3'b100);
        acc(1'b0, 1'b0, LARGE_SEL_ADDR, 16'h0000, 3'b100);
        chk("denied", 16'hffff, cpuRdata);
    endtask
    task automatic externalModes;
        restart(1'b0, 1'b1, 1'b1);
        acc(1'b0, 1'b0, 16'h7ffe, 16'h0000, 3'b010);
        chk("ext addr", 16'h7ffe, extAddr);
        acc(1'b1, 1'b1, MODE_CTL_ADDR, 16'h0100, 3'b100);
        acc(1'b0, 1'b0, MODE_CTL_ADDR, 16'h0000, 3'b100);
        chk("locked", 16'hffff, cpuRdata);
        restart(1'b1, 1'b0, 1'b0);
        acc(1'b1, 1'b1, SMALL_SEL_ADDR, 16'h00a5, 3'b001);
        chk("ext data", 16'h00a5, extWdata);
        acc(1'b0, 1'b1, 16'hff81, 16'h0000, 3'b010);
        chk("ext addr", 16'hff81, extAddr);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        regResetValues;
        programFlow;
        supplyOff;
        externalModes;
        bootBaud;
        close_out;
    end
    // the whole run needs a few hundred states; a hang ends here
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_errors++;
        close_out;
    end
endmodule
`default_nettype wire
